/* rtl/field_hold.sv */
// Loadable holding register with a constant reset value
`timescale 1ns/1ps
`default_nettype none
module field_hold #(
  parameter int W = 16,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Load port
  input wire logic ld,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_q;

  always_comb begin
    nxt_q = ld ? d : q_ff;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q_ff <= RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;
endmodule : field_hold
`default_nettype wire

/* rtl/np_tx_cfg.svh */
// Offsets, field positions and reset values of the next-page transmit block
`ifndef NP_TX_CFG_SVH
`define NP_TX_CFG_SVH
`define APB_AW 12
`define APB_DW 32
`define NPT_OFF 12'h0e8
`define NPL_OFF 12'h100
`define CTL_OFF 12'h104
`define STS_OFF 12'h108
`define NPT_W 16
`define NPT_RESET 16'h2001
`define NPT_NP_BIT 15
`define NPT_RSV_BIT 14
`define NPT_MP_BIT 13
`define NPT_ACK_BIT 12
`define NPT_TG_BIT 11
`define CODE_W 11
`define CODE_RESET 11'h001
`define ST_W 4
`define CTL_EN_BIT 0
`define STS_PEND_BIT 4
`define STS_VALID_BIT 5
`define STS_DONE_BIT 6
`define STS_FIRST_BIT 7
`endif

/* rtl/np_tx_pkg.sv */
// Types shared by the next-page transmit block
`include "np_tx_cfg.svh"
package np_tx_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`APB_AW-1:0] paddr;
    logic [`APB_DW-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic more_pages_flag;
    logic rsvd;
    logic page_type_flag;
    logic comply_acknowledge;
    logic toggle;
    logic [`CODE_W-1:0] code;
  } np_word_t;

  typedef enum logic [`ST_W-1:0] {
    ST_IDLE = 4'h1,
    ST_WAIT_BASE = 4'h2,
    ST_SEND = 4'h4,
    ST_DONE = 4'h8
  } state_t;
endpackage : np_tx_pkg

/* rtl/port2_next_page_transmit.sv */
// Port 2 next-page transmit word, page sequencing and APB register access
`timescale 1ns/1ps
`default_nettype none
`include "np_tx_cfg.svh"
module port2_next_page_transmit (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // APB slave
  input wire np_tx_pkg::apb_req_t APB_REQ,
  output logic [`APB_DW-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Auto-negotiation arbiter side
  input wire logic BASE_DONE,
  input wire logic BASE_TOGGLE,
  input wire logic PAGE_ACK,
  output var np_tx_pkg::np_word_t NP_WORD,
  output logic NP_VALID
);
  import np_tx_pkg::*;

  // Bus decode
  logic setup;
  logic access;
  logic sel_npt;
  logic sel_npl;
  logic sel_ctl;
  logic sel_sts;
  logic mapped;
  logic wr;

  assign setup = APB_REQ.psel && !APB_REQ.penable;
  assign access = APB_REQ.psel && APB_REQ.penable;
  assign sel_npt = APB_REQ.paddr == `NPT_OFF;
  assign sel_npl = APB_REQ.paddr == `NPL_OFF;
  assign sel_ctl = APB_REQ.paddr == `CTL_OFF;
  assign sel_sts = APB_REQ.paddr == `STS_OFF;
  assign mapped = sel_npt || sel_npl || sel_ctl || sel_sts;
  assign wr = access && APB_REQ.pwrite && mapped;
  // Zero-wait slave: every access phase completes in its first cycle
  assign PREADY = access;
  assign PSLVERR = access && !mapped;

  // Sequencing state
  state_t state_ff;
  state_t nxt_state;
  logic base_tog_ff;
  logic nxt_base_tog;
  logic first_ff;
  logic nxt_first;
  logic pending_ff;
  logic nxt_pending;
  logic valid_ff;
  logic nxt_valid;
  logic done_ff;
  logic nxt_done;
  logic loaded_ff;
  logic nxt_loaded;
  logic enable_ff;
  logic nxt_enable;
  logic [`APB_DW-1:0] prdata_ff;
  logic [`APB_DW-1:0] nxt_prdata;

  // Staged and transmitted words
  np_word_t stage_q;
  np_word_t stage_d;
  np_word_t word_q;
  np_word_t word_d;
  logic stage_ld;
  logic word_ld;
  logic last_ack;

  // A load is refused while staged content waits; software polls pending
  assign stage_ld = wr && sel_npl && !pending_ff;
  // Words go out only after the base page and one at a time
  assign word_ld = (state_ff == ST_SEND) && pending_ff && !valid_ff && enable_ff;
  assign last_ack = valid_ff && PAGE_ACK && !word_q.more_pages_flag;

  always_comb begin
    stage_d = np_word_t'(APB_REQ.pwdata[`NPT_W-1:0]);
    stage_d.rsvd = 1'b0;
    stage_d.toggle = 1'b0;
    word_d = stage_q;
    word_d.rsvd = 1'b0;
    // First page inverts the base bit, later ones invert the last word
    word_d.toggle = first_ff ? !base_tog_ff : !word_q.toggle;
  end

  field_hold #(
    .W(`NPT_W),
    .RST(`NPT_RESET)
  ) u_stage (
    .clk(CLK),
    .arst_n(ARST_N),
    .ld(stage_ld),
    .d(stage_d),
    .q(stage_q)
  );

  // Holds bit 15, 13, 12, toggle and code with their reset values
  field_hold #(
    .W(`NPT_W),
    .RST(`NPT_RESET)
  ) u_word (
    .clk(CLK),
    .arst_n(ARST_N),
    .ld(word_ld),
    .d(word_d),
    .q(word_q)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_base_tog = base_tog_ff;
    nxt_first = first_ff;
    nxt_pending = pending_ff;
    nxt_valid = valid_ff;
    nxt_done = done_ff;
    nxt_loaded = loaded_ff || word_ld;
    nxt_enable = enable_ff;
    if (wr && sel_ctl) begin
      nxt_enable = APB_REQ.pwdata[`CTL_EN_BIT];
    end
    if (stage_ld) begin
      nxt_pending = 1'b1;
    end
    if (word_ld) begin
      nxt_pending = 1'b0;
      nxt_valid = 1'b1;
      nxt_first = 1'b0;
    end
    if (valid_ff && PAGE_ACK) begin
      nxt_valid = 1'b0;
    end
    case (state_ff)
      ST_IDLE: begin
        if (enable_ff) begin
          nxt_state = ST_WAIT_BASE;
        end
      end
      ST_WAIT_BASE, ST_DONE: begin
        if (BASE_DONE) begin
          nxt_state = ST_SEND;
          nxt_base_tog = BASE_TOGGLE;
          nxt_first = 1'b1;
        end
      end
      ST_SEND: begin
        if (last_ack) begin
          nxt_state = ST_DONE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (!enable_ff) begin
      nxt_state = ST_IDLE;
      nxt_valid = 1'b0;
    end
    // Hardware set wins over a same-cycle software clear
    if (wr && sel_sts && APB_REQ.pwdata[`STS_DONE_BIT]) begin
      nxt_done = 1'b0;
    end
    if (state_ff == ST_SEND && last_ack) begin
      nxt_done = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff <= ST_IDLE;
      base_tog_ff <= 1'b0;
      first_ff <= 1'b0;
      pending_ff <= 1'b0;
      valid_ff <= 1'b0;
      done_ff <= 1'b0;
      loaded_ff <= 1'b0;
      enable_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      base_tog_ff <= nxt_base_tog;
      first_ff <= nxt_first;
      pending_ff <= nxt_pending;
      valid_ff <= nxt_valid;
      done_ff <= nxt_done;
      loaded_ff <= nxt_loaded;
      enable_ff <= nxt_enable;
    end
  end

  // Read data is sampled in the setup cycle so PRDATA comes from a flop
  always_comb begin
    nxt_prdata = prdata_ff;
    if (setup) begin
      nxt_prdata = '0;
      if (sel_npt) begin
        nxt_prdata[`NPT_W-1:0] = word_q;
      end else if (sel_npl) begin
        nxt_prdata[`NPT_W-1:0] = stage_q;
      end else if (sel_ctl) begin
        nxt_prdata[`CTL_EN_BIT] = enable_ff;
      end else if (sel_sts) begin
        nxt_prdata[`ST_W-1:0] = state_ff;
        nxt_prdata[`STS_PEND_BIT] = pending_ff;
        nxt_prdata[`STS_VALID_BIT] = valid_ff;
        nxt_prdata[`STS_DONE_BIT] = done_ff;
        nxt_prdata[`STS_FIRST_BIT] = first_ff;
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prdata_ff <= '0;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign PRDATA = prdata_ff;
  assign NP_WORD = word_q;
  assign NP_VALID = valid_ff;

  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  sequence seq_rd_setup;
    APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite && APB_REQ.paddr == `NPT_OFF;
  endsequence

  sequence seq_rd_access;
    APB_REQ.psel && APB_REQ.penable && PREADY && $stable(APB_REQ.paddr);
  endsequence

  sequence seq_last_ack;
    NP_VALID && PAGE_ACK && !NP_WORD.more_pages_flag && state_ff == ST_SEND;
  endsequence

  chk_last_page_end: assert property (
    seq_last_ack and enable_ff |=> state_ff == ST_DONE && !NP_VALID && done_ff
  ) else $error("last page did not end the exchange");

  chk_more_pages_go: assert property (
    NP_VALID && PAGE_ACK && NP_WORD.more_pages_flag && enable_ff |=> state_ff == ST_SEND
  ) else $error("exchange left send state with more pages flagged");

  chk_page_type_rst: assert property (
    !loaded_ff |-> NP_WORD.page_type_flag
  ) else $error("page type flag not one before first load");

  chk_comply_rst: assert property (
    !loaded_ff |-> !NP_WORD.comply_acknowledge && NP_WORD[`NPT_ACK_BIT] == 1'b0
  ) else $error("comply acknowledge not zero before first load");

  chk_toggle_alt: assert property (
    word_ld && !first_ff |=> NP_WORD[`NPT_TG_BIT] != $past(NP_WORD[`NPT_TG_BIT]) && NP_VALID
  ) else $error("toggle bit did not alternate");

  chk_toggle_first: assert property (
    word_ld && first_ff |=> NP_WORD[`NPT_TG_BIT] == !$past(base_tog_ff)
  ) else $error("first next page toggle not inverse of base bit");

  chk_code_rst: assert property (
    !loaded_ff |-> NP_WORD.code == `CODE_RESET && !NP_WORD.more_pages_flag
  ) else $error("code field not at reset value before first load");

  chk_word_read: assert property (
    seq_rd_setup ##1 seq_rd_access |-> PRDATA[`NPT_W-1:0] == $past(NP_WORD) &&
      !PRDATA[`NPT_RSV_BIT] && PRDATA[`APB_DW-1:`NPT_W] == '0
  ) else $error("word read back wrong or reserved bit set");

  chk_after_base: assert property (
    NP_VALID |-> state_ff == ST_SEND && !first_ff && loaded_ff
  ) else $error("next page offered outside a base-page exchange");

  chk_valid_holds: assert property (
    NP_VALID && !PAGE_ACK && enable_ff |=> NP_VALID && $stable(NP_WORD)
  ) else $error("next page dropped before acknowledge");
endmodule : port2_next_page_transmit
`default_nettype wire

/* verification/np_partner.sv */
// Remote link partner model for the next-page exchange
`timescale 1ns/1ps
`default_nettype none
module np_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control from bench
  input wire logic go,
  input wire logic btog,
  input wire logic [1:0] dly,
  // Link side
  input wire logic np_valid,
  output logic base_done,
  output logic base_toggle,
  output logic page_ack
);
  logic [1:0] cnt_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      base_done <= 1'b0;
      base_toggle <= 1'b0;
      page_ack <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      base_done <= go;
      // Outside the base pulse the line wanders, so a stale sample shows up
      base_toggle <= go ? btog : ~base_toggle;
      if (page_ack || !np_valid) begin
        page_ack <= 1'b0;
        cnt_ff <= 2'h0;
      end else if (cnt_ff == dly) begin
        page_ack <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 2'h1;
      end
    end
  end
endmodule : np_partner
`default_nettype wire

/* verification/test_port2_next_page_transmit.sv */
// Self-checking bench for the port 2 next-page transmit block
`timescale 1ns/1ps
`default_nettype none
`include "np_tx_cfg.svh"
module test_port2_next_page_transmit;
  import np_tx_pkg::*;
  logic CLK = 1'b0;
  logic ARST_N = 1'b0;
  apb_req_t req = '0;
  logic [31:0] prdata;
  logic pready, pslverr, base_done, base_toggle, page_ack, np_valid;
  np_word_t np_word;
  logic go = 1'b0;
  logic btog = 1'b0;
  logic [1:0] dly = 2'h0;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic se;
  logic [15:0] stg;
  logic tg;
  int np;

  always #2 CLK = ~CLK;

  port2_next_page_transmit u_dut (.CLK(CLK), .ARST_N(ARST_N), .APB_REQ(req),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .BASE_DONE(base_done),
    .BASE_TOGGLE(base_toggle), .PAGE_ACK(page_ack), .NP_WORD(np_word),
    .NP_VALID(np_valid));

  np_partner u_far (.clk(CLK), .arst_n(ARST_N), .go(go), .btog(btog), .dly(dly),
    .np_valid(np_valid), .base_done(base_done), .base_toggle(base_toggle),
    .page_ack(page_ack));

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk

  // One APB transfer; waits on pready, one idle cycle after; only the timeout ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge CLK);
    req.penable <= 1'b1;
    do begin
      @(posedge CLK);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge CLK);
  endtask : apb

  // Sampled mid-cycle so the edge's updates have landed
  task automatic wait_valid(input logic lvl);
    int n;
    n = 0;
    @(negedge CLK);
    while (np_valid !== lvl && n < 200) begin
      @(negedge CLK);
      n++;
    end
    chk("np_valid", 32'(lvl), 32'(np_valid));
    @(posedge CLK);
  endtask : wait_valid

  function automatic logic [15:0] exp_word(input logic [15:0] s, input logic t);
    return {s[15], 1'b0, s[13:12], t, s[10:0]};
  endfunction : exp_word

  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    void'($urandom(32'h0aa7));
    repeat (10) @(posedge CLK);
    ARST_N <= 1'b1;
    @(posedge CLK);
    chk("reset word", 32'h2001, {16'h0, np_word});
    apb(1'b0, `NPT_OFF, 32'h0);
    chk("read word", 32'h2001, rd);
    chk("mapped err", 32'h0, 32'(se));
    apb(1'b1, `NPT_OFF, 32'h0000ffff);
    apb(1'b0, `NPT_OFF, 32'h0);
    chk("read-only word", 32'h2001, rd);
    apb(1'b0, 12'h0f0, 32'h0);
    chk("unmapped err", 32'h1, 32'(se));
    $display("test reset and access done");
    apb(1'b1, `CTL_OFF, 32'h1);
    chk("valid before base", 32'h0, 32'(np_valid));
    // First exchange is a lone last page, the second restarts from done
    for (int b = 0; b < 2; b++) begin
      btog <= b[0];
      go <= 1'b1;
      @(posedge CLK);
      go <= 1'b0;
      tg = ~b[0];
      np = b ? $urandom_range(4, 2) : 1;
      for (int p = 0; p < np; p++) begin
        stg = 16'($urandom);
        stg[15] = (p != np - 1);
        dly <= 2'($urandom);
        apb(1'b1, `NPL_OFF, {16'h0, stg});
        wait_valid(1'b1);
        chk("word", {16'h0, exp_word(stg, tg)}, {16'h0, np_word});
        apb(1'b0, `NPT_OFF, 32'h0);
        chk("reg word", {16'h0, exp_word(stg, tg)}, rd);
        wait_valid(1'b0);
        tg = ~tg;
      end
      apb(1'b0, `STS_OFF, 32'h0);
      chk("done flag", 32'h1, 32'(rd[`STS_DONE_BIT]));
      $display("test exchange %0d done", b);
    end
    // Sticky done clears by writing one; enable off drops back to idle
    apb(1'b1, `STS_OFF, 32'h1 << `STS_DONE_BIT);
    apb(1'b0, `STS_OFF, 32'h0);
    chk("done cleared", 32'h0, 32'(rd[`STS_DONE_BIT]));
    chk("state done", 32'h8, 32'(rd[`ST_W-1:0]));
    apb(1'b1, `CTL_OFF, 32'h0);
    apb(1'b0, `STS_OFF, 32'h0);
    chk("state idle", 32'h1, 32'(rd[`ST_W-1:0]));
    // Outside the send state a staged word waits, so a second load is refused
    stg = 16'($urandom);
    apb(1'b1, `NPL_OFF, {16'h0, stg});
    apb(1'b1, `NPL_OFF, {16'h0, ~stg});
    apb(1'b0, `NPL_OFF, 32'h0);
    chk("stage held", {16'h0, exp_word(stg, 1'b0)}, rd);
    chk("valid when idle", 32'h0, 32'(np_valid));
    $display("test clear and refuse done");
    conclude();
  end
endmodule : test_port2_next_page_transmit
`default_nettype wire
